// file: rtl/pcm_consts.vh
// Purpose: constants for the upper port C pin function mux
// Assumes: 3-bit function select per pin, code 0 is general-purpose I/O
// Notes:   codes not listed for a pin fall back to general-purpose I/O
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

`define PCM_SEL_W          3
`define PCM_NPINS          6

// common code
`define PCM_FN_GPIO        3'h0

// pin 10
`define PCM_FN10_MOSI      3'h1
`define PCM_FN10_XBAR_IN5  3'h2
`define PCM_FN10_MISO      3'h3
`define PCM_FN10_SCLK      3'h4
// pin 11
`define PCM_FN11_CAN_TX    3'h1
`define PCM_FN11_TW1_CLK   3'h2
`define PCM_FN11_SER1_TX   3'h3
// pin 12
`define PCM_FN12_CAN_RX    3'h1
`define PCM_FN12_TW1_DAT   3'h2
`define PCM_FN12_SER1_RX   3'h3
// pin 13
`define PCM_FN13_TMR_A3    3'h1
`define PCM_FN13_XBAR_IN6  3'h2
// pin 14
`define PCM_FN14_TW0_DAT   3'h1
`define PCM_FN14_XBAR_OUT0 3'h2
// pin 15
`define PCM_FN15_TW0_CLK   3'h1
`define PCM_FN15_XBAR_OUT1 3'h2

// reset values
`define PCM_SEL_RST        18'h00000
`define PCM_DIR_RST        6'h00
`define PCM_OE_N_RST       6'h3F
`define PCM_OUT_RST        6'h00
`define PCM_SYNC_RST       6'h3F

`endif

// file: rtl/pcm_port_c_upper_mux.v
// Purpose: function mux for port C pins 10 to 15
// Assumes: one clock clk_i (50 MHz), async active-low reset rst_n_i
// Notes:   pad bit 0 is pin 10 ... bit 5 is pin 15; pad_oe_n_o low drives
// Behaviour
// - each pin individually GPIO input or output
// - pins come up as GPIO after reset
// - SPI clock: output as master, input slave
// - MOSI: output as master, input as slave
// - MISO: input master, output slave, Z unselected
// - CAN transmit open-drain; CAN receive input
// - serial channel 1 transmit; single-wire shares pin
`include "pcm_consts.vh"

module pcm_port_c_upper_mux #(
    parameter NPINS = `PCM_NPINS
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    // configuration
    input  wire             cfg_load_i,
    input  wire [17:0]      cfg_sel_i,
    input  wire [NPINS-1:0] cfg_dir_i,
    input  wire [NPINS-1:0] gpio_out_i,
    output wire [NPINS-1:0] gpio_in_o,
    output wire [17:0]      sel_o,
    output wire [NPINS-1:0] dir_o,
    // pads
    input  wire [NPINS-1:0] pad_in_i,
    output wire [NPINS-1:0] pad_out_o,
    output wire [NPINS-1:0] pad_oe_n_o,
    // spi
    input  wire             spi_master_i,
    input  wire             spi_slave_sel_i,
    input  wire             spi_sclk_out_i,
    input  wire             spi_mosi_out_i,
    input  wire             spi_miso_out_i,
    output reg              spi_sclk_in_o,
    output reg              spi_mosi_in_o,
    output reg              spi_miso_in_o,
    // can
    input  wire             can_transmit_pin_i,
    output reg              can_receive_pin_o,
    // async serial channel 1
    input  wire             async_serial1_transmit_i,
    input  wire             async_serial1_single_wire_i,
    input  wire             async_serial1_tx_dir_i,
    output reg              async_serial1_receive_o,
    // two-wire 1 and 0 (out low = pull line low)
    input  wire             two_wire1_clock_i,
    input  wire             two_wire1_data_i,
    input  wire             two_wire0_clock_i,
    input  wire             two_wire0_data_i,
    output reg              two_wire1_clock_o,
    output reg              two_wire1_data_o,
    output reg              two_wire0_clock_o,
    output reg              two_wire0_data_o,
    // quad timer a channel 3
    input  wire             quad_timer_a_channel3_i,
    input  wire             quad_timer_a_channel3_oe_i,
    output reg              quad_timer_a_channel3_o,
    // crossbar
    input  wire             crossbar_output_0_i,
    input  wire             crossbar_output_1_i,
    output reg              crossbar_input_5_o,
    output reg              crossbar_input_6_o
);

    reg [17:0]      sel_q;
    reg [NPINS-1:0] dir_q;
    reg [NPINS-1:0] sync1_q;
    reg [NPINS-1:0] sync2_q;
    reg [NPINS-1:0] sync3_q;
    reg [NPINS-1:0] filt_q;
    reg [NPINS-1:0] out_q;
    reg [NPINS-1:0] oe_n_q;
    reg [NPINS-1:0] out_d;
    reg [NPINS-1:0] oe_n_d;

    wire [NPINS-1:0] agree;
    wire [NPINS-1:0] filt_d;
    wire [2:0]       s10;
    wire [2:0]       s11;
    wire [2:0]       s12;
    wire [2:0]       s13;
    wire [2:0]       s14;
    wire [2:0]       s15;

    assign s10 = sel_q[2:0];
    assign s11 = sel_q[5:3];
    assign s12 = sel_q[8:6];
    assign s13 = sel_q[11:9];
    assign s14 = sel_q[14:12];
    assign s15 = sel_q[17:15];

    // open-drain: drive low for a 0, release for a 1
    function od_oe_n;
        input d;
        begin
            od_oe_n = d;
        end
    endfunction

    // input value seen by a peripheral; idle level when not routed
    function route_in;
        input en;
        input pin;
        input idle;
        begin
            route_in = en ? pin : idle;
        end
    endfunction

    // a change counts once the second and third stages agree
    assign agree  = ~(sync2_q ^ sync3_q);
    assign filt_d = (sync3_q & agree) | (filt_q & ~agree);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= `PCM_SYNC_RST;
            sync2_q <= `PCM_SYNC_RST;
            sync3_q <= `PCM_SYNC_RST;
            filt_q  <= `PCM_SYNC_RST;
        end else begin
            sync1_q <= pad_in_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= `PCM_SEL_RST;
            dir_q <= `PCM_DIR_RST;
        end else if (cfg_load_i) begin
            sel_q <= cfg_sel_i;
            dir_q <= cfg_dir_i;
        end
    end

    always @* begin
        // gpio per pin by default
        out_d  = gpio_out_i;
        oe_n_d = ~dir_q;

        // pin 10
        if (s10 == `PCM_FN10_MOSI) begin
            out_d[0]  = spi_mosi_out_i;
            oe_n_d[0] = ~spi_master_i;
        end else if (s10 == `PCM_FN10_XBAR_IN5) begin
            out_d[0]  = 1'b0;
            oe_n_d[0] = 1'b1;
        end else if (s10 == `PCM_FN10_MISO) begin
            out_d[0]  = spi_miso_out_i;
            oe_n_d[0] = spi_master_i | ~spi_slave_sel_i;
        end else if (s10 == `PCM_FN10_SCLK) begin
            out_d[0]  = spi_sclk_out_i;
            oe_n_d[0] = ~spi_master_i;
        end

        // pin 11
        if (s11 == `PCM_FN11_CAN_TX) begin
            out_d[1]  = 1'b0;
            oe_n_d[1] = od_oe_n(can_transmit_pin_i);
        end else if (s11 == `PCM_FN11_TW1_CLK) begin
            out_d[1]  = 1'b0;
            oe_n_d[1] = od_oe_n(two_wire1_clock_i);
        end else if (s11 == `PCM_FN11_SER1_TX) begin
            out_d[1]  = async_serial1_transmit_i;
            oe_n_d[1] = async_serial1_single_wire_i &
                        ~async_serial1_tx_dir_i;
        end

        // pin 12
        if (s12 == `PCM_FN12_CAN_RX || s12 == `PCM_FN12_SER1_RX) begin
            out_d[2]  = 1'b0;
            oe_n_d[2] = 1'b1;
        end else if (s12 == `PCM_FN12_TW1_DAT) begin
            out_d[2]  = 1'b0;
            oe_n_d[2] = od_oe_n(two_wire1_data_i);
        end

        // pin 13
        if (s13 == `PCM_FN13_TMR_A3) begin
            out_d[3]  = quad_timer_a_channel3_i;
            oe_n_d[3] = ~quad_timer_a_channel3_oe_i;
        end else if (s13 == `PCM_FN13_XBAR_IN6) begin
            out_d[3]  = 1'b0;
            oe_n_d[3] = 1'b1;
        end

        // pin 14
        if (s14 == `PCM_FN14_TW0_DAT) begin
            out_d[4]  = 1'b0;
            oe_n_d[4] = od_oe_n(two_wire0_data_i);
        end else if (s14 == `PCM_FN14_XBAR_OUT0) begin
            out_d[4]  = crossbar_output_0_i;
            oe_n_d[4] = 1'b0;
        end

        // pin 15
        if (s15 == `PCM_FN15_TW0_CLK) begin
            out_d[5]  = 1'b0;
            oe_n_d[5] = od_oe_n(two_wire0_clock_i);
        end else if (s15 == `PCM_FN15_XBAR_OUT1) begin
            out_d[5]  = crossbar_output_1_i;
            oe_n_d[5] = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_q  <= `PCM_OUT_RST;
            oe_n_q <= `PCM_OE_N_RST;
        end else begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    // peripheral inputs from the filtered pins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_sclk_in_o           <= 1'b0;
            spi_mosi_in_o           <= 1'b0;
            spi_miso_in_o           <= 1'b0;
            can_receive_pin_o       <= 1'b1;
            async_serial1_receive_o <= 1'b1;
            two_wire1_clock_o       <= 1'b1;
            two_wire1_data_o        <= 1'b1;
            two_wire0_clock_o       <= 1'b1;
            two_wire0_data_o        <= 1'b1;
            quad_timer_a_channel3_o <= 1'b0;
            crossbar_input_5_o      <= 1'b0;
            crossbar_input_6_o      <= 1'b0;
        end else begin
            spi_sclk_in_o <= route_in(s10 == `PCM_FN10_SCLK &&
                                      !spi_master_i, filt_q[0], 1'b0);
            spi_mosi_in_o <= route_in(s10 == `PCM_FN10_MOSI &&
                                      !spi_master_i, filt_q[0], 1'b0);
            spi_miso_in_o <= route_in(s10 == `PCM_FN10_MISO &&
                                      spi_master_i, filt_q[0], 1'b0);
            can_receive_pin_o <= route_in(s12 == `PCM_FN12_CAN_RX,
                                          filt_q[2], 1'b1);
            if (s11 == `PCM_FN11_SER1_TX && async_serial1_single_wire_i)
                async_serial1_receive_o <= filt_q[1];
            else
                async_serial1_receive_o <= route_in(s12 == `PCM_FN12_SER1_RX,
                                                    filt_q[2], 1'b1);
            two_wire1_clock_o <= route_in(s11 == `PCM_FN11_TW1_CLK,
                                          filt_q[1], 1'b1);
            two_wire1_data_o  <= route_in(s12 == `PCM_FN12_TW1_DAT,
                                          filt_q[2], 1'b1);
            two_wire0_data_o  <= route_in(s14 == `PCM_FN14_TW0_DAT,
                                          filt_q[4], 1'b1);
            two_wire0_clock_o <= route_in(s15 == `PCM_FN15_TW0_CLK,
                                          filt_q[5], 1'b1);
            quad_timer_a_channel3_o <= route_in(s13 == `PCM_FN13_TMR_A3,
                                                filt_q[3], 1'b0);
            crossbar_input_5_o <= route_in(s10 == `PCM_FN10_XBAR_IN5,
                                           filt_q[0], 1'b0);
            crossbar_input_6_o <= route_in(s13 == `PCM_FN13_XBAR_IN6,
                                           filt_q[3], 1'b0);
        end
    end

    assign pad_out_o  = out_q;
    assign pad_oe_n_o = oe_n_q;
    assign gpio_in_o  = filt_q;
    assign sel_o      = sel_q;
    assign dir_o      = dir_q;

endmodule // pcm_port_c_upper_mux

// file: dv/pcm_mux_props.sv
// Purpose: port-level checks for the upper port C pin function mux
// Assumes: pad outputs follow the stored select and inputs one edge later
// Notes:   bound to the mux from the bench top file
module pcm_mux_props #(
    parameter int NPINS = 6
) (
    input logic             clk_i,
    input logic             rst_n_i,
    input logic             cfg_load_i,
    input logic [17:0]      cfg_sel_i,
    input logic [NPINS-1:0] cfg_dir_i,
    input logic [NPINS-1:0] gpio_out_i,
    input logic [17:0]      sel_o,
    input logic [NPINS-1:0] dir_o,
    input logic [NPINS-1:0] pad_out_o,
    input logic [NPINS-1:0] pad_oe_n_o,
    input logic             spi_master_i,
    input logic             spi_slave_sel_i,
    input logic             spi_sclk_out_i,
    input logic             can_transmit_pin_i,
    input logic             async_serial1_transmit_i,
    input logic             async_serial1_single_wire_i,
    input logic             async_serial1_tx_dir_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    reset_gpio_a: assert property (
        $rose(rst_n_i) |-> sel_o == 18'h0 && pad_oe_n_o == 6'h3F)
        else $error("pins not released as gpio after reset");
    sel_load_a: assert property (cfg_load_i |=>
        sel_o == $past(cfg_sel_i) && dir_o == $past(cfg_dir_i))
        else $error("stored select or direction not loaded");
    gpio_dir_a: assert property ($past(sel_o[11:9]) == 3'h0 |->
        pad_oe_n_o[3] == !$past(dir_o[3]) &&
        (!$past(dir_o[3]) || pad_out_o[3] == $past(gpio_out_i[3])))
        else $error("gpio direction or data not on pad");
    sclk_role_a: assert property ($past(sel_o[2:0]) == 3'h4 |->
        pad_oe_n_o[0] == !$past(spi_master_i) &&
        (pad_oe_n_o[0] || pad_out_o[0] == $past(spi_sclk_out_i)))
        else $error("spi clock direction wrong for role");
    mosi_role_a: assert property ($past(sel_o[2:0]) == 3'h1 |->
        pad_oe_n_o[0] == !$past(spi_master_i))
        else $error("mosi direction wrong for role");
    miso_hiz_a: assert property ($past(sel_o[2:0]) == 3'h3 |->
        pad_oe_n_o[0] == ($past(spi_master_i) || !$past(spi_slave_sel_i)))
        else $error("miso driven when it must be released");
    can_od_a: assert property ($past(sel_o[5:3]) == 3'h1 |->
        !pad_out_o[1] && pad_oe_n_o[1] == $past(can_transmit_pin_i))
        else $error("can transmit not open drain");
    can_rx_a: assert property ($past(sel_o[8:6]) == 3'h1 |->
        pad_oe_n_o[2])
        else $error("can receive pin driven");
    sci_tx_a: assert property ($past(sel_o[5:3]) == 3'h3 |->
        pad_oe_n_o[1] == ($past(async_serial1_single_wire_i) &&
        !$past(async_serial1_tx_dir_i)) && (pad_oe_n_o[1] ||
        pad_out_o[1] == $past(async_serial1_transmit_i)))
        else $error("serial transmit pin drive wrong");
endmodule // pcm_mux_props

// file: dv/pcm_pad_world.sv
// Purpose: pads and far-side drivers of the upper port C pins
// Assumes: every pad has a pull-up; the far side only pulls low
// Notes:   a pad pulled low by either side reads low
module pcm_pad_world #(
    parameter int NPINS = 6
) (
    input  logic [NPINS-1:0] pad_out_i,
    input  logic [NPINS-1:0] pad_oe_n_i,
    input  logic [NPINS-1:0] ext_low_i,
    output logic [NPINS-1:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and against the pull-up keeps released pads from floating
    assign pad_o = (pad_oe_n_i | pad_out_i) & ~ext_low_i;
endmodule // pcm_pad_world

// file: dv/pcm_port_c_upper_mux_bench.sv
// Purpose: self-checking bench for the upper port C pin function mux
// Assumes: inputs change on the falling edge; pads have pull-ups
// Notes:   waits of 2 and 6 cycles cover pad drive and pad sampling
module pcm_port_c_upper_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ld = 1'b0;
    logic [17:0] sel = 18'h0;
    logic [17:0] selo;
    logic [5:0]  dir = 6'h0, gout = 6'h0, ext = 6'h0;
    logic [5:0]  pad, gin, dro, pout, poe_n;
    logic [16:0] pv = 17'h1E20; // two-wire released, can recessive
    logic [11:0] pin_o;
    int          failures = 0, checks = 0;

    always #10 clk_i = ~clk_i;

    pcm_port_c_upper_mux pcm_port_c_upper_mux_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_load_i(ld), .cfg_sel_i(sel),
        .cfg_dir_i(dir), .gpio_out_i(gout), .gpio_in_o(gin), .sel_o(selo),
        .dir_o(dro), .pad_in_i(pad), .pad_out_o(pout), .pad_oe_n_o(poe_n),
        .spi_master_i(pv[0]), .spi_slave_sel_i(pv[1]),
        .spi_sclk_out_i(pv[2]), .spi_mosi_out_i(pv[3]),
        .spi_miso_out_i(pv[4]), .spi_sclk_in_o(pin_o[0]),
        .spi_mosi_in_o(pin_o[1]), .spi_miso_in_o(pin_o[2]),
        .can_transmit_pin_i(pv[5]), .can_receive_pin_o(pin_o[3]),
        .async_serial1_transmit_i(pv[6]),
        .async_serial1_single_wire_i(pv[7]),
        .async_serial1_tx_dir_i(pv[8]), .async_serial1_receive_o(pin_o[4]),
        .two_wire1_clock_i(pv[9]), .two_wire1_data_i(pv[10]),
        .two_wire0_clock_i(pv[11]), .two_wire0_data_i(pv[12]),
        .two_wire1_clock_o(pin_o[5]), .two_wire1_data_o(pin_o[6]),
        .two_wire0_clock_o(pin_o[7]), .two_wire0_data_o(pin_o[8]),
        .quad_timer_a_channel3_i(pv[13]), .quad_timer_a_channel3_oe_i(pv[14]),
        .quad_timer_a_channel3_o(pin_o[9]), .crossbar_output_0_i(pv[15]),
        .crossbar_output_1_i(pv[16]), .crossbar_input_5_o(pin_o[10]),
        .crossbar_input_6_o(pin_o[11]));

    pcm_pad_world pcm_pad_world_inst (.pad_out_i(pout), .pad_oe_n_i(poe_n),
        .ext_low_i(ext), .pad_o(pad));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic cfg(input logic [17:0] s, input logic [5:0] d, input int n);
        ld = 1'b1;
        sel = s;
        dir = d;
        w(1);
        ld = 1'b0;
        w(n);
    endtask

    task automatic t_reset;
        chk(selo, 18'h0);
        chk(poe_n, 6'h3F);
        ld = 1'b1;
        sel = 18'h00001;
        w(1);
        sel = 18'h08000;
        w(1);
        ld = 1'b0;
        chk(selo, 18'h08000);
    endtask

    task automatic t_gpio;
        logic [5:0] d;
        gout = 6'h33;
        for (int i = 0; i < 2; i++) begin
            d = i ? 6'h2A : 6'h15;
            ext = ~d;
            cfg(18'h0, d, 6);
            chk(dro, d);
            chk(poe_n, d ^ 6'h3F);
            chk(pout & d, 6'h33 & d);
            chk(gin, 6'h33 & d);
        end
        ext = 6'h00;
        gout = 6'h00;
    endtask

    task automatic t_spi;
        logic e;
        for (int c = 1; c < 5; c++) if (c != 2) for (int k = 0; k < 4; k++) begin
            pv[1:0] = 2'(k);
            e = (c == 3) ? (k[0] | ~k[1]) : ~k[0];
            cfg(18'(c), 6'h0, 2);
            chk(poe_n[0], e);
        end
        pv[1:0] = 2'b00;
        cfg(18'h4, 6'h0, 6);
        chk(pin_o[0], 1'b1);
        cfg(18'h1, 6'h0, 6);
        chk(pin_o[1], 1'b1);
    endtask

    task automatic t_can;
        pv[5] = 1'b0;
        cfg(18'h00048, 6'h0, 2);
        chk({poe_n[2:1], pout[1]}, 3'b100);
        pv[5] = 1'b1;
        ext = 6'h04;
        w(6);
        chk(poe_n[1], 1'b1);
        chk(pin_o[3], 1'b0);
        ext = 6'h00;
    endtask

    task automatic t_sci;
        pv[8:6] = 3'b001;
        cfg(18'h00018, 6'h0, 2);
        chk({poe_n[1], pout[1]}, 2'b01);
        pv[8:6] = 3'b010;
        ext = 6'h02;
        w(7);
        chk(poe_n[1], 1'b1);
        chk(pin_o[4], 1'b0);
        ext = 6'h00;
        pv[8:6] = 3'b110;
        w(2);
        chk({poe_n[1], pout[1]}, 2'b00);
    endtask

    // two-wire, timer and crossbar routes, then miso as master input
    task automatic t_alt;
        pv[14:9] = 6'b110110;
        cfg(18'h09292, 6'h0, 7);
        chk({poe_n, pout}, 12'h948);
        chk(gin, 6'h2D);
        chk(pin_o, 12'h6D8);
        pv[16:15] = 2'b01;
        pv[0] = 1'b1;
        ext = 6'h04;
        cfg(18'h124C3, 6'h0, 7);
        chk({poe_n, pout[5:4]}, 8'h3D);
        chk(gin, 6'h1B);
        chk(pin_o, 12'h9EC);
        pv = 17'h1E20;
        ext = 6'h00;
    endtask

    // reset in mid-run returns every pin to gpio input
    task automatic t_rst2;
        rst_n_i = 1'b0;
        w(2);
        chk(selo, 18'h0);
        chk({dro, poe_n, gin}, 18'h00FFF);
        rst_n_i = 1'b1;
        w(2);
        chk(poe_n, 6'h3F);
        chk(pin_o, 12'h1F8);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        w(12);
        rst_n_i = 1'b1;
        t_reset();
        t_gpio();
        t_spi();
        t_can();
        t_sci();
        t_alt();
        t_rst2();
        tally_and_finish();
    end

    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule // pcm_port_c_upper_mux_bench

bind pcm_port_c_upper_mux pcm_mux_props #(.NPINS(NPINS)) pcm_mux_props_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_load_i(cfg_load_i),
    .cfg_sel_i(cfg_sel_i), .cfg_dir_i(cfg_dir_i), .gpio_out_i(gpio_out_i),
    .sel_o(sel_o), .dir_o(dir_o), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .spi_master_i(spi_master_i),
    .spi_slave_sel_i(spi_slave_sel_i), .spi_sclk_out_i(spi_sclk_out_i),
    .can_transmit_pin_i(can_transmit_pin_i),
    .async_serial1_transmit_i(async_serial1_transmit_i),
    .async_serial1_single_wire_i(async_serial1_single_wire_i),
    .async_serial1_tx_dir_i(async_serial1_tx_dir_i));
